// ==== core/iad_defines.svh ====
`ifndef IAD_DEFINES_SVH
`define IAD_DEFINES_SVH

// ****************************************
// Address field layout, reset and idle values
// ****************************************
`define IAD_ADDR_W       10
`define IAD_BASE_MSB     9
`define IAD_BASE_LSB     5
`define IAD_BASE_W       5
`define IAD_REG_MSB      4
`define IAD_REG_LSB      0
`define IAD_REG_W        5
`define IAD_BLOCK_SIZE   32
`define IAD_BASE_RST     5'h1f
`define IAD_REG_RST      5'h00
`define IAD_ADDR_RST     10'h000
`define IAD_STROBE_IDLE  1'h1
`define IAD_AEN_IDLE     1'h0
`define IAD_SEL_RST      1'h0

`endif

// ==== core/iad_pkg.sv ====
package iad_pkg;
  `include "iad_defines.svh"
  typedef logic [`IAD_BASE_W-1:0] iad_base_t;
  typedef logic [`IAD_REG_W-1:0]  iad_reg_t;
endpackage

// ==== core/iad_decoder.sv ====
`timescale 1ns/1ps
`include "iad_defines.svh"

// ****************************************
// Two-stage synchroniser
// ****************************************
// Nothing outside may read the first stage: it can still be metastable
module iad_sync2
  import iad_pkg::*;
#(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      meta <= RST_VAL;
    end else begin
      meta <= d_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q_o <= RST_VAL;
    end else begin
      q_o <= meta;
    end
  end

endmodule // iad_sync2

// ****************************************
// Host I/O address decoder
// ****************************************
module iad_decoder
  import iad_pkg::*;
(
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_i,
  input  wire logic [`IAD_ADDR_W-1:0] host_addr_i,
  input  wire logic                   host_ior_n_i,
  input  wire logic                   host_iow_n_i,
  input  wire logic                   host_aen_i,
  input  wire logic                   base_jumper_bit0_i,
  input  wire logic                   base_jumper_bit1_i,
  input  wire logic                   base_jumper_bit2_i,
  input  wire logic                   base_jumper_bit3_i,
  input  wire logic                   base_jumper_bit4_i,
  output logic                        board_sel_o,
  output logic                        rd_sel_o,
  output logic                        wr_sel_o,
  output iad_reg_t                    reg_sel_o,
  output iad_base_t                   base_addr_o
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  // Bus pins come from outside this clock domain. The address is a word
  // taken without handshake: the host holds it steady around the strobe,
  // so it has settled before the synchronised strobe qualifies it.
  logic [`IAD_ADDR_W-1:0] addr_sync;
  logic                   ior_n_sync;
  logic                   iow_n_sync;
  logic                   aen_sync;
  iad_base_t              jmp_pins;
  iad_base_t              jmp_sync;

  // Open jumper pulled up reads 1, fitted shorts to 0
  assign jmp_pins = {base_jumper_bit4_i,
                     base_jumper_bit3_i,
                     base_jumper_bit2_i,
                     base_jumper_bit1_i,
                     base_jumper_bit0_i};

  iad_sync2 #(
    .WIDTH   (`IAD_ADDR_W),
    .RST_VAL (`IAD_ADDR_RST)
  ) addr_sync_inst (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .d_i       (host_addr_i),
    .q_o       (addr_sync)
  );

  iad_sync2 #(
    .WIDTH   (1),
    .RST_VAL (`IAD_STROBE_IDLE)
  ) ior_sync_inst (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .d_i       (host_ior_n_i),
    .q_o       (ior_n_sync)
  );

  iad_sync2 #(
    .WIDTH   (1),
    .RST_VAL (`IAD_STROBE_IDLE)
  ) iow_sync_inst (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .d_i       (host_iow_n_i),
    .q_o       (iow_n_sync)
  );

  iad_sync2 #(
    .WIDTH   (1),
    .RST_VAL (`IAD_AEN_IDLE)
  ) aen_sync_inst (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .d_i       (host_aen_i),
    .q_o       (aen_sync)
  );

  iad_sync2 #(
    .WIDTH   (`IAD_BASE_W),
    .RST_VAL (`IAD_BASE_RST)
  ) jmp_sync_inst (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .d_i       (jmp_pins),
    .q_o       (jmp_sync)
  );

  // ****************************************
  // Cycle decode
  // ****************************************
  logic      rd_cyc;
  logic      wr_cyc;
  logic      hit;
  logic      claim;
  iad_base_t addr_base;
  iad_reg_t  addr_reg;

  assign addr_base = addr_sync[`IAD_BASE_MSB:`IAD_BASE_LSB];
  assign addr_reg  = addr_sync[`IAD_REG_MSB:`IAD_REG_LSB];

  // Memory cycles use other strobes and never reach here; AEN marks DMA
  assign rd_cyc = ~ior_n_sync & ~aen_sync;
  assign wr_cyc = ~iow_n_sync & ~aen_sync;

  // Both strobes low is illegal on the host; both selects would then rise
  // Only upper bits compared, so exactly one 32-location block matches
  assign hit    = (addr_base == jmp_sync);
  assign claim  = hit & (rd_cyc | wr_cyc);

  // ****************************************
  // Select outputs
  // ****************************************
  // Three edges from pin to output: two sync stages and this flop
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      board_sel_o <= `IAD_SEL_RST;
    end else begin
      board_sel_o <= claim;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rd_sel_o <= `IAD_SEL_RST;
    end else begin
      rd_sel_o <= hit & rd_cyc;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wr_sel_o <= `IAD_SEL_RST;
    end else begin
      wr_sel_o <= hit & wr_cyc;
    end
  end

  // ****************************************
  // Register select and base
  // ****************************************
  // Held at zero outside a claimed cycle to avoid stray selects
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      reg_sel_o <= `IAD_REG_RST;
    end else if (claim) begin
      reg_sel_o <= addr_reg;
    end else begin
      reg_sel_o <= `IAD_REG_RST;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      base_addr_o <= `IAD_BASE_RST;
    end else begin
      base_addr_o <= jmp_sync;
    end
  end

endmodule // iad_decoder

// ==== bench/iad_host_model.sv ====
`timescale 1ns/1ps
module iad_host_model (
  input  wire logic       ref_clk_i,
  output logic      [9:0] host_addr_o,
  output logic            host_ior_n_o,
  output logic            host_iow_n_o,
  output logic            host_aen_o
);
  logic [12:0] bus = 13'h0006;
  assign {host_addr_o, host_ior_n_o, host_iow_n_o, host_aen_o} = bus;
  // Released bus shows the inverted address, never a held value
  task automatic drive(logic [9:0] a, logic rd, ae, on);
    @(posedge ref_clk_i) bus <= on ? {a, !rd, rd, ae} : {~bus[12:3], 3'h6};
  endtask
endmodule // iad_host_model

// ==== bench/iad_decoder_checker.sv ====
`timescale 1ns/1ps
module iad_decoder_checker
  import iad_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic [9:0] host_addr_i,
  input  wire logic       host_ior_n_i,
  input  wire logic       host_iow_n_i,
  input  wire logic       host_aen_i,
  input  wire logic       base_jumper_bit0_i,
  input  wire logic       base_jumper_bit1_i,
  input  wire logic       base_jumper_bit2_i,
  input  wire logic       base_jumper_bit3_i,
  input  wire logic       base_jumper_bit4_i,
  input  wire logic       board_sel_o,
  input  wire logic       rd_sel_o,
  input  wire logic       wr_sel_o,
  input  wire iad_reg_t   reg_sel_o,
  input  wire iad_base_t  base_addr_o
);
  wire [4:0] j = {base_jumper_bit4_i, base_jumper_bit3_i, base_jumper_bit2_i,
                  base_jumper_bit1_i, base_jumper_bit0_i};
  wire       hit = !host_aen_i && !(host_ior_n_i && host_iow_n_i) && host_addr_i[9:5] == j;
  wire [4:0] ra = hit ? host_addr_i[4:0] : 5'h00;
  wire [1:0] rw = {hit & !host_ior_n_i, hit & !host_iow_n_i};
  logic [1:0] up;
  // Sync pipeline must hold only post-reset samples before checks start
  always_ff @(posedge ref_clk_i) up <= rst_i ? 2'h0 : up + 2'(up != 2'h3);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i || up != 2'h3);
  a_claim_block: assert property (board_sel_o == $past(hit, 3))
    else $error("claim");
  a_base_jumper: assert property (base_addr_o == $past(j, 3))
    else $error("base");
  a_reg_select: assert property (reg_sel_o == $past(ra, 3))
    else $error("reg");
  a_strobe_kind: assert property ({rd_sel_o, wr_sel_o} == $past(rw, 3))
    else $error("kind");
  a_dma_ignored: assert property ($past(host_aen_i, 3) |-> !board_sel_o)
    else $error("aen");
  c_read: cover property (rd_sel_o);
  c_write: cover property (wr_sel_o);
  c_top_reg: cover property (board_sel_o && reg_sel_o == 5'h1f);
  c_dma_cycle: cover property (host_aen_i && !host_ior_n_i);
endmodule // iad_decoder_checker
bind iad_decoder iad_decoder_checker iad_decoder_checker_inst (
  .ref_clk_i          (ref_clk_i),
  .rst_i              (rst_i),
  .host_addr_i        (host_addr_i),
  .host_ior_n_i       (host_ior_n_i),
  .host_iow_n_i       (host_iow_n_i),
  .host_aen_i         (host_aen_i),
  .base_jumper_bit0_i (base_jumper_bit0_i),
  .base_jumper_bit1_i (base_jumper_bit1_i),
  .base_jumper_bit2_i (base_jumper_bit2_i),
  .base_jumper_bit3_i (base_jumper_bit3_i),
  .base_jumper_bit4_i (base_jumper_bit4_i),
  .board_sel_o        (board_sel_o),
  .rd_sel_o           (rd_sel_o),
  .wr_sel_o           (wr_sel_o),
  .reg_sel_o          (reg_sel_o),
  .base_addr_o        (base_addr_o)
);

// ==== bench/iad_decoder_tb.sv ====
`timescale 1ns/1ps
module iad_decoder_tb import iad_pkg::*;;
  logic ref_clk_i = 1'h0, rst_i = 1'h1, host_ior_n_i, host_iow_n_i, host_aen_i, board_sel_o;
  logic rd_sel_o, wr_sel_o;
  logic [9:0] host_addr_i;
  iad_reg_t reg_sel_o;
  iad_base_t base_addr_o, j = 5'h16;
  int num_errors = 0, num_checks = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  iad_host_model iad_host_model_inst (.ref_clk_i, .host_addr_o(host_addr_i),
    .host_ior_n_o(host_ior_n_i), .host_iow_n_o(host_iow_n_i), .host_aen_o(host_aen_i));
  iad_decoder iad_decoder_inst (.*, .base_jumper_bit0_i(j[0]), .base_jumper_bit1_i(j[1]),
    .base_jumper_bit2_i(j[2]), .base_jumper_bit3_i(j[3]), .base_jumper_bit4_i(j[4]));
  task automatic check(string n, logic [12:0] seen, exp);
    num_checks++;
    if (seen !== exp) $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    num_errors += int'(seen !== exp);
  endtask
  // Entries: jumpers, address, read, aen, claimed; block edges and both ends of I/O space
  task automatic t_decode;
    logic [17:0] t [8] = '{{5'h16, 10'h2c3, 3'h5}, {5'h16, 10'h2df, 3'h1}, {5'h16, 10'h2bf, 3'h4},
      {5'h16, 10'h2e0, 3'h0}, {5'h16, 10'h2c5, 3'h6}, {5'h00, 10'h01f, 3'h5},
      {5'h1f, 10'h3e0, 3'h1}, {5'h1f, 10'h020, 3'h4}};
    foreach (t[i]) begin
      @(posedge ref_clk_i) j <= t[i][17:13];
      iad_host_model_inst.drive(t[i][12:3], t[i][2], t[i][1], 1'h1);
      repeat (4) @(posedge ref_clk_i);
      #1;
      check("base", 13'(base_addr_o), 13'(t[i][17:13]));
      check("claim", 13'(board_sel_o), 13'(t[i][0]));
      check("read", 13'(rd_sel_o), 13'(t[i][0] & t[i][2]));
      check("write", 13'(wr_sel_o), 13'(t[i][0] & !t[i][2]));
      check("reg", 13'(reg_sel_o), t[i][0] ? 13'(t[i][7:3]) : 13'h0000);
      iad_host_model_inst.drive(t[i][12:3], t[i][2], t[i][1], 1'h0);
      repeat (4) @(posedge ref_clk_i);
      #1;
      check("released", 13'({board_sel_o, rd_sel_o, wr_sel_o, reg_sel_o}), 13'h0000);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'h0;
    t_decode();
    final_report();
  end
  initial begin
    #40us;
    num_errors++;
    final_report();
  end
endmodule // iad_decoder_tb
